// ==== dtp_defines.vh ====
/*
 * Constants of the dual eight-bit timer pair: register indices, field
 * positions, reset values and clock select codes.
 * Assumes it is included by its bare name from the design files.
 */
`ifndef DTP_DEFINES_VH
`define DTP_DEFINES_VH

// ============================================================
// Register indices (byte address is four times the index)
`define DTP_IDX_CTRL 8'hB6
`define DTP_IDX_HCNT 8'hB8
`define DTP_IDX_LCNT 8'hB9
`define DTP_IDX_HCMP 8'hBA
`define DTP_IDX_LCMP 8'hBB
`define DTP_IDX_IRQ_STS 8'hC0
`define DTP_IDX_IRQ_MASK 8'hC1
`define DTP_IDX_FLAGS 8'hC2

// ============================================================
// Control register fields
`define DTP_CTRL_HLVL 7
`define DTP_CTRL_HSEL_MSB 6
`define DTP_CTRL_HSEL_LSB 4
`define DTP_CTRL_LLVL 3
`define DTP_CTRL_LSEL_MSB 2
`define DTP_CTRL_LSEL_LSB 0

// Flag register fields
`define DTP_FLAG_HOVF 7
`define DTP_FLAG_EDGE 0

// Interrupt status / mask bit positions and width
`define DTP_IRQ_HOVF 0
`define DTP_IRQ_LOVF 1
`define DTP_IRQ_HCMP 2
`define DTP_IRQ_LCMP 3
`define DTP_IRQ_W 4

// ============================================================
// Clock select codes (three bits); codes below 3'h4 are the cascade
// or external event choice
`define DTP_SEL_DIV32 3'h4
`define DTP_SEL_DIV16 3'h5
`define DTP_SEL_DIV4 3'h6
`define DTP_SEL_DIV2 3'h7

// ============================================================
// Reset values and counter maximum
`define DTP_RST_CTRL 8'h00
`define DTP_RST_CNT 8'h00
`define DTP_RST_CMP 8'hFF
`define DTP_CNT_MAX 8'hFF

// Bus answers
`define DTP_RESP_OKAY 2'h0
`define DTP_RESP_SLVERR 2'h2

`endif

// ==== dtp_half.v ====
/*
 * One eight-bit half of the timer pair: counter, compare match and the
 * toggle output.
 * Assumes the parent supplies a one-cycle count tick and write strobes
 * all on the same clock.
 */
`timescale 1ns/1ps
`include "dtp_defines.vh"

module dtp_half (
	input wire i_mclk, // System clock
	input wire i_rst_n, // Synchronous reset, active low
	input wire i_tick, // Count enable pulse
	input wire i_cnt_we, // Software write of the counter
	input wire [7:0] i_cnt_wd, // Counter write data
	input wire [7:0] i_cmp, // Compare value
	input wire i_lvl_we, // Load output level
	input wire i_lvl, // Level to load
	output wire [7:0] o_cnt, // Count value
	output wire o_ovf, // Pulse on rollover FF to 00
	output wire o_match, // Pulse when count reaches compare
	output wire o_out // Toggle output level
);

	reg [7:0] cnt_q; // Counter
	reg [7:0] cnt_d; // Next count
	reg out_q; // Toggle output
	wire inc; // Counter advances this cycle

	// ============================================================
	// Count and rollover
	// A software write wins over a tick in the same cycle, so the
	// written value is never lost to a simultaneous increment.
	assign inc = i_tick & ~i_cnt_we;
	assign o_ovf = inc & (cnt_q == `DTP_CNT_MAX);
	assign o_match = inc & (cnt_d == i_cmp);

	// Next count
	always @* begin
		if (i_cnt_we) begin
			cnt_d = i_cnt_wd; // RULE10
		end else if (i_tick) begin
			cnt_d = cnt_q + 8'h01; // RULE10
		end else begin
			cnt_d = cnt_q;
		end
	end

	// Counter and output flops
	always @(posedge i_mclk) begin
		if (!i_rst_n) begin
			cnt_q <= `DTP_RST_CNT;
			out_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			if (i_lvl_we) begin
				out_q <= i_lvl; // RULE7 RULE8
			end else if (o_match) begin
				out_q <= ~out_q;
			end
		end
	end

	assign o_cnt = cnt_q;
	assign o_out = out_q;

endmodule // dtp_half

// ==== dtp_timer.v ====
/*
 * Dual eight-bit timer pair with AXI4-Lite register access, compare
 * toggle outputs, high-half overflow flag and a masked interrupt.
 * Assumes one system clock, a synchronous active-low reset and an
 * external event pin that is asynchronous to the clock.
 */
// The AXI4-Lite interface to the registers is this design's own decision.
// Function
// RULE1 - High counter rollover FF to 00 sets flag
// RULE2 - Flag clears only by read-one then write-zero
// RULE3 - Writing one to the flag does nothing
// RULE4 - Cascade mode counts low-half overflows
// RULE5 - Low source: event edge or clock/32,16,4,2
// RULE6 - High source: clock divided by 32,16,4,2
// RULE7 - High level bit sets high output level
// RULE8 - Low level bit sets low output level
// RULE9 - Control register write-only, eight bits, resets zero
// RULE10 - Counters increment per tick, software accessible
`timescale 1ns/1ps
`include "dtp_defines.vh"

module dtp_timer (
	input wire i_mclk, // System clock, 200 MHz
	input wire i_rst_n, // Synchronous reset, active low
	input wire i_external_event_input, // Event pin, asynchronous
	input wire [31:0] i_s_axi_awaddr, // Write address
	input wire i_s_axi_awvalid, // Write address valid
	output reg o_s_axi_awready, // Write address ready
	input wire [31:0] i_s_axi_wdata, // Write data
	input wire [3:0] i_s_axi_wstrb, // Write byte strobes
	input wire i_s_axi_wvalid, // Write data valid
	output reg o_s_axi_wready, // Write data ready
	output reg [1:0] o_s_axi_bresp, // Write response
	output reg o_s_axi_bvalid, // Write response valid
	input wire i_s_axi_bready, // Write response ready
	input wire [31:0] i_s_axi_araddr, // Read address
	input wire i_s_axi_arvalid, // Read address valid
	output reg o_s_axi_arready, // Read address ready
	output reg [31:0] o_s_axi_rdata, // Read data
	output reg [1:0] o_s_axi_rresp, // Read response
	output reg o_s_axi_rvalid, // Read data valid
	input wire i_s_axi_rready, // Read data ready
	output reg o_high_out, // High-half timer output
	output reg o_low_out, // Low-half timer output
	output reg o_irq // Interrupt, active high level
);

	// ============================================================
	// Declarations
	reg [7:0] ctrl_q; // Timer pair control, write-only
	reg [7:0] hcmp_q; // High compare
	reg [7:0] lcmp_q; // Low compare
	reg hovf_q; // High-half overflow flag
	reg hovf_armed_q; // Flag was read as one
	reg edge_q; // External edge select, 1 = falling
	reg [`DTP_IRQ_W-1:0] irq_sts_q; // Sticky interrupt status
	reg [`DTP_IRQ_W-1:0] irq_mask_q; // Interrupt mask
	reg [4:0] presc_q; // Free-running prescaler
	reg ev_s1_q; // Event synchroniser stage one
	reg ev_s2_q; // Event synchroniser stage two
	reg ev_s3_q; // Delayed event for edge detect
	reg aw_held_q; // Write address captured
	reg w_held_q; // Write data captured
	reg [7:0] aw_idx_q; // Captured write index
	reg aw_bad_q; // Captured write address is misaligned or out of range
	reg [31:0] wdata_q; // Captured write data
	reg wstrb0_q; // Captured low byte strobe
	reg [31:0] rdata_d; // Read mux
	reg rhit_d; // Read index is mapped
	reg [3:0] div_tick; // Ticks for /2, /4, /16, /32
	reg ltick; // Low count tick
	reg htick; // High count tick
	wire ev_rise; // Synchronised rising edge
	wire ev_fall; // Synchronised falling edge
	wire do_wr; // Register write this cycle
	wire wr_lo; // Low byte is written
	wire [7:0] wd; // Write byte
	wire [7:0] ar_idx; // Read index
	wire do_rd; // Read taken this cycle
	wire [7:0] hcnt; // High count
	wire [7:0] lcnt; // Low count
	wire hovf_p; // High rollover pulse
	wire lovf_p; // Low rollover pulse
	wire hmatch_p; // High compare match
	wire lmatch_p; // Low compare match
	wire hout; // High toggle level
	wire lout; // Low toggle level
	wire ctrl_we; // Control register write
	wire [`DTP_IRQ_W-1:0] irq_evt; // Interrupt events
	wire [`DTP_IRQ_W-1:0] irq_sts_d; // Next status

	// ============================================================
	// Prescaler and divided ticks
	// One shared prescaler keeps both halves phase-aligned; a tick of
	// clock/N is the cycle in which the low log2(N) bits are all ones.
	always @(posedge i_mclk) begin
		if (!i_rst_n) begin
			presc_q <= 5'h00;
		end else begin
			presc_q <= presc_q + 5'h01;
		end
	end

	// Divided tick decode
	always @* begin
		div_tick[0] = presc_q[0];
		div_tick[1] = &presc_q[1:0];
		div_tick[2] = &presc_q[3:0];
		div_tick[3] = &presc_q[4:0];
	end

	// ============================================================
	// External event synchroniser and edge detect
	always @(posedge i_mclk) begin
		if (!i_rst_n) begin
			ev_s1_q <= 1'b0;
			ev_s2_q <= 1'b0;
			ev_s3_q <= 1'b0;
		end else begin
			ev_s1_q <= i_external_event_input;
			ev_s2_q <= ev_s1_q;
			ev_s3_q <= ev_s2_q;
		end
	end

	assign ev_rise = ev_s2_q & ~ev_s3_q;
	assign ev_fall = ~ev_s2_q & ev_s3_q;

	// ============================================================
	// Clock source selection
	// Low half
	always @* begin
		case (ctrl_q[`DTP_CTRL_LSEL_MSB:`DTP_CTRL_LSEL_LSB])
			`DTP_SEL_DIV32: ltick = div_tick[3]; // RULE5
			`DTP_SEL_DIV16: ltick = div_tick[2]; // RULE5
			`DTP_SEL_DIV4: ltick = div_tick[1]; // RULE5
			`DTP_SEL_DIV2: ltick = div_tick[0]; // RULE5
			default: ltick = edge_q ? ev_fall : ev_rise; // RULE5
		endcase
	end

	// High half
	always @* begin
		case (ctrl_q[`DTP_CTRL_HSEL_MSB:`DTP_CTRL_HSEL_LSB])
			`DTP_SEL_DIV32: htick = div_tick[3]; // RULE6
			`DTP_SEL_DIV16: htick = div_tick[2]; // RULE6
			`DTP_SEL_DIV4: htick = div_tick[1]; // RULE6
			`DTP_SEL_DIV2: htick = div_tick[0]; // RULE6
			default: htick = lovf_p; // RULE4
		endcase
	end

	// ============================================================
	// AXI4-Lite write channel
	// Address and data are taken independently and held until both are
	// present; the write then happens in one cycle and bvalid follows.
	assign do_wr = aw_held_q & w_held_q & ~o_s_axi_bvalid;
	assign wr_lo = do_wr & wstrb0_q & ~aw_bad_q;
	assign wd = wdata_q[7:0];
	assign ctrl_we = wr_lo & (aw_idx_q == `DTP_IDX_CTRL);

	// Write handshake
	always @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_s_axi_awready <= 1'b0;
			o_s_axi_wready <= 1'b0;
			o_s_axi_bvalid <= 1'b0;
			o_s_axi_bresp <= `DTP_RESP_OKAY;
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			aw_idx_q <= 8'h00;
			aw_bad_q <= 1'b0;
			wdata_q <= 32'h00000000;
			wstrb0_q <= 1'b0;
		end else begin
			o_s_axi_awready <= ~aw_held_q & ~o_s_axi_awready & i_s_axi_awvalid;
			o_s_axi_wready <= ~w_held_q & ~o_s_axi_wready & i_s_axi_wvalid;
			if (o_s_axi_awready & i_s_axi_awvalid) begin
				aw_held_q <= 1'b1;
				aw_idx_q <= i_s_axi_awaddr[9:2];
				aw_bad_q <= (i_s_axi_awaddr[1:0] != 2'h0) | (i_s_axi_awaddr[31:10] != 22'h000000);
			end
			if (o_s_axi_wready & i_s_axi_wvalid) begin
				w_held_q <= 1'b1;
				wdata_q <= i_s_axi_wdata;
				wstrb0_q <= i_s_axi_wstrb[0];
			end
			if (do_wr) begin
				o_s_axi_bvalid <= 1'b1;
				o_s_axi_bresp <= (aw_bad_q | ~wr_hit(aw_idx_q)) ? `DTP_RESP_SLVERR : `DTP_RESP_OKAY;
			end else if (o_s_axi_bvalid & i_s_axi_bready) begin
				o_s_axi_bvalid <= 1'b0;
				aw_held_q <= 1'b0;
				w_held_q <= 1'b0;
			end
		end
	end

	// Mapped write index
	function wr_hit;
		input [7:0] idx;
		begin
			wr_hit = (idx == `DTP_IDX_CTRL) | (idx == `DTP_IDX_HCNT) | (idx == `DTP_IDX_LCNT) |
				(idx == `DTP_IDX_HCMP) | (idx == `DTP_IDX_LCMP) | (idx == `DTP_IDX_IRQ_STS) |
				(idx == `DTP_IDX_IRQ_MASK) | (idx == `DTP_IDX_FLAGS);
		end
	endfunction

	// ============================================================
	// Configuration registers
	always @(posedge i_mclk) begin
		if (!i_rst_n) begin
			ctrl_q <= `DTP_RST_CTRL; // RULE9
			hcmp_q <= `DTP_RST_CMP;
			lcmp_q <= `DTP_RST_CMP;
			irq_mask_q <= {`DTP_IRQ_W{1'b0}};
			edge_q <= 1'b0;
		end else if (wr_lo) begin
			if (aw_idx_q == `DTP_IDX_CTRL) begin
				ctrl_q <= wd; // RULE9
			end
			if (aw_idx_q == `DTP_IDX_HCMP) begin
				hcmp_q <= wd;
			end
			if (aw_idx_q == `DTP_IDX_LCMP) begin
				lcmp_q <= wd;
			end
			if (aw_idx_q == `DTP_IDX_IRQ_MASK) begin
				irq_mask_q <= wd[`DTP_IRQ_W-1:0];
			end
			if (aw_idx_q == `DTP_IDX_FLAGS) begin
				edge_q <= wd[`DTP_FLAG_EDGE];
			end
		end
	end

	// ============================================================
	// Counter halves
	// Low half
	dtp_half u_low (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_tick(ltick),
		.i_cnt_we(wr_lo & (aw_idx_q == `DTP_IDX_LCNT)),
		.i_cnt_wd(wd),
		.i_cmp(lcmp_q),
		.i_lvl_we(ctrl_we),
		.i_lvl(wd[`DTP_CTRL_LLVL]),
		.o_cnt(lcnt),
		.o_ovf(lovf_p),
		.o_match(lmatch_p),
		.o_out(lout)
	);

	// High half
	dtp_half u_high (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_tick(htick),
		.i_cnt_we(wr_lo & (aw_idx_q == `DTP_IDX_HCNT)),
		.i_cnt_wd(wd),
		.i_cmp(hcmp_q),
		.i_lvl_we(ctrl_we),
		.i_lvl(wd[`DTP_CTRL_HLVL]),
		.o_cnt(hcnt),
		.o_ovf(hovf_p),
		.o_match(hmatch_p),
		.o_out(hout)
	);

	// ============================================================
	// High-half overflow flag
	// Clearing needs a read that saw the flag set followed by a write of
	// zero; a rollover in the clearing cycle still wins.
	always @(posedge i_mclk) begin
		if (!i_rst_n) begin
			hovf_q <= 1'b0;
			hovf_armed_q <= 1'b0;
		end else begin
			if (hovf_p) begin
				hovf_q <= 1'b1; // RULE1
			end else if (wr_lo & (aw_idx_q == `DTP_IDX_FLAGS) & ~wd[`DTP_FLAG_HOVF] &
				hovf_armed_q) begin
				hovf_q <= 1'b0; // RULE2 RULE3
			end
			if (do_rd & (ar_idx == `DTP_IDX_FLAGS)) begin
				hovf_armed_q <= hovf_q; // RULE2
			end else if (wr_lo & (aw_idx_q == `DTP_IDX_FLAGS)) begin
				hovf_armed_q <= 1'b0;
			end
		end
	end

	// ============================================================
	// Interrupt status, mask and output
	assign irq_evt = {lmatch_p, hmatch_p, lovf_p, hovf_p};
	assign irq_sts_d = irq_evt | (irq_sts_q &
		~((wr_lo & (aw_idx_q == `DTP_IDX_IRQ_STS)) ? wd[`DTP_IRQ_W-1:0] : {`DTP_IRQ_W{1'b0}}));

	// Sticky status and registered outputs
	always @(posedge i_mclk) begin
		if (!i_rst_n) begin
			irq_sts_q <= {`DTP_IRQ_W{1'b0}};
			o_irq <= 1'b0;
			o_high_out <= 1'b0;
			o_low_out <= 1'b0;
		end else begin
			irq_sts_q <= irq_sts_d;
			o_irq <= |(irq_sts_d & irq_mask_q);
			o_high_out <= hout; // RULE7
			o_low_out <= lout; // RULE8
		end
	end

	// ============================================================
	// AXI4-Lite read channel
	assign ar_idx = i_s_axi_araddr[9:2];
	assign do_rd = o_s_axi_arready & i_s_axi_arvalid;

	// Read mux; the control register is write-only and reads zero
	always @* begin
		rhit_d = 1'b1;
		case (ar_idx)
			`DTP_IDX_CTRL: rdata_d = 32'h00000000; // RULE9
			`DTP_IDX_HCNT: rdata_d = {24'h000000, hcnt}; // RULE10
			`DTP_IDX_LCNT: rdata_d = {24'h000000, lcnt}; // RULE10
			`DTP_IDX_HCMP: rdata_d = {24'h000000, hcmp_q};
			`DTP_IDX_LCMP: rdata_d = {24'h000000, lcmp_q};
			`DTP_IDX_IRQ_STS: rdata_d = {28'h0000000, irq_sts_q};
			`DTP_IDX_IRQ_MASK: rdata_d = {28'h0000000, irq_mask_q};
			`DTP_IDX_FLAGS: rdata_d = {24'h000000, hovf_q, 6'h00, edge_q};
			default: begin
				rdata_d = 32'h00000000;
				rhit_d = 1'b0;
			end
		endcase
		if ((i_s_axi_araddr[1:0] != 2'h0) | (i_s_axi_araddr[31:10] != 22'h000000)) begin
			rhit_d = 1'b0;
			rdata_d = 32'h00000000;
		end
	end

	// Read handshake: address taken, answer in the next cycle
	always @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_s_axi_arready <= 1'b0;
			o_s_axi_rvalid <= 1'b0;
			o_s_axi_rdata <= 32'h00000000;
			o_s_axi_rresp <= `DTP_RESP_OKAY;
		end else begin
			o_s_axi_arready <= ~o_s_axi_arready & ~o_s_axi_rvalid & i_s_axi_arvalid;
			if (do_rd) begin
				o_s_axi_rvalid <= 1'b1;
				o_s_axi_rdata <= rdata_d;
				o_s_axi_rresp <= rhit_d ? `DTP_RESP_OKAY : `DTP_RESP_SLVERR;
			end else if (o_s_axi_rvalid & i_s_axi_rready) begin
				o_s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule // dtp_timer

// ==== dtp_checker.sv ====
/* Checker for dtp_timer: bus handshakes, reset state and output levels.
   Assumes one clock and is attached to dtp_timer by bind. */
`timescale 1ns/1ps
`include "dtp_defines.vh"
module dtp_checker (
	input wire i_mclk, // Clock
	input wire i_rst_n, // Reset, active low
	input wire [31:0] i_s_axi_awaddr, // Write address
	input wire i_s_axi_awvalid, // Write address valid
	input wire o_s_axi_awready, // Write address ready
	input wire [31:0] i_s_axi_wdata, // Write data
	input wire [3:0] i_s_axi_wstrb, // Write strobes
	input wire i_s_axi_wvalid, // Write data valid
	input wire o_s_axi_wready, // Write data ready
	input wire [1:0] o_s_axi_bresp, // Write response
	input wire o_s_axi_bvalid, // Write response valid
	input wire i_s_axi_bready, // Write response ready
	input wire i_s_axi_arvalid, // Read address valid
	input wire o_s_axi_arready, // Read address ready
	input wire [31:0] o_s_axi_rdata, // Read data
	input wire o_s_axi_rvalid, // Read data valid
	input wire i_s_axi_rready, // Read data ready
	input wire o_high_out, // High output
	input wire o_low_out, // Low output
	input wire o_irq // Interrupt
);
	// ============================================================
	// Common clock and reset
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	// Both write channels taken at one edge
	sequence s_wr_taken;
		i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
	endsequence
	// Control write selecting the event and cascade sources, so no clock divider tick causes a match toggle
	sequence s_ctrl_wr;
		s_wr_taken ##0 (i_s_axi_awaddr == {22'h000000, `DTP_IDX_CTRL, 2'h0}) && i_s_axi_wstrb[0]
			&& !i_s_axi_wdata[2] && !i_s_axi_wdata[6];
	endsequence
	sequence s_rd_taken;
		i_s_axi_arvalid && o_s_axi_arready;
	endsequence
	property p_reset_out;
		$rose(i_rst_n) |-> !o_irq && !o_high_out && !o_low_out && !o_s_axi_bvalid;
	endproperty
	property p_level_load;
		s_ctrl_wr |-> ##3 (o_high_out == $past(i_s_axi_wdata[7], 3))
			&& (o_low_out == $past(i_s_axi_wdata[3], 3));
	endproperty
	property p_b_hold;
		o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp);
	endproperty
	property p_r_hold;
		o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata);
	endproperty
	property p_aw_pulse;
		o_s_axi_awready |=> !o_s_axi_awready;
	endproperty
	property p_ar_cause;
		$rose(o_s_axi_arready) |-> $past(i_s_axi_arvalid);
	endproperty
	property p_b_after;
		s_wr_taken |-> ##[1:3] o_s_axi_bvalid;
	endproperty
	property p_r_next;
		s_rd_taken |=> o_s_axi_rvalid;
	endproperty
	a_reset_out: assert property (p_reset_out) else $error("outputs not idle after reset");
	a_level_load: assert property (p_level_load) else $error("output level not loaded");
	a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
	a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
	a_aw_pulse: assert property (p_aw_pulse) else $error("awready longer than one cycle");
	a_ar_cause: assert property (p_ar_cause) else $error("arready without arvalid");
	a_b_after: assert property (p_b_after) else $error("write response late");
	a_r_next: assert property (p_r_next) else $error("read data late");
endmodule // dtp_checker

bind dtp_timer dtp_checker chk_u (.i_mclk, .i_rst_n, .i_s_axi_awaddr, .i_s_axi_awvalid,
	.o_s_axi_awready, .i_s_axi_wdata, .i_s_axi_wstrb, .i_s_axi_wvalid, .o_s_axi_wready,
	.o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_arvalid, .o_s_axi_arready,
	.o_s_axi_rdata, .o_s_axi_rvalid, .i_s_axi_rready, .o_high_out, .o_low_out, .o_irq);

// ==== dtp_timer_test.sv ====
/* Self-checking bench for dtp_timer over AXI4-Lite.
   Assumes dtp_defines.vh on the include path; 200 MHz clock. */
`timescale 1ns/1ps
`include "dtp_defines.vh"
module dtp_timer_test;
	// ============================================================
	// Stimulus and observed signals
	reg i_mclk = 1'b0; // Clock
	reg i_rst_n = 1'b0; // Reset, active low
	reg ev = 1'b0; // Event pin
	reg [31:0] awa = 32'h0, wd = 32'h0, ara = 32'h0; // Bus payloads
	reg [3:0] ws = 4'h0; // Write strobes
	reg awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0; // Handshakes
	wire awr, wr_rdy, bv, arr, rv, ho, lo, irq; // Design outputs
	wire [1:0] bresp, rresp; // Responses
	wire [31:0] rdata; // Read data
	integer n_errors = 0, n_tests = 0; // Counters
	integer k; // Loop index
	reg [31:0] rd; // Last read word
	reg [1:0] rs; // Last response
	localparam [31:0] A_CTRL = `DTP_IDX_CTRL * 4, A_HCNT = `DTP_IDX_HCNT * 4;
	localparam [31:0] A_LCNT = `DTP_IDX_LCNT * 4, A_HCMP = `DTP_IDX_HCMP * 4;
	localparam [31:0] A_LCMP = `DTP_IDX_LCMP * 4, A_STS = `DTP_IDX_IRQ_STS * 4;
	localparam [31:0] A_MASK = `DTP_IDX_IRQ_MASK * 4, A_FLG = `DTP_IDX_FLAGS * 4;
	always #2.5 i_mclk = ~i_mclk;
	dtp_timer dut_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_external_event_input(ev),
		.i_s_axi_awaddr(awa), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr),
		.i_s_axi_wdata(wd), .i_s_axi_wstrb(ws), .i_s_axi_wvalid(wv), .o_s_axi_wready(wr_rdy),
		.o_s_axi_bresp(bresp), .o_s_axi_bvalid(bv), .i_s_axi_bready(br),
		.i_s_axi_araddr(ara), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr),
		.o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rv),
		.i_s_axi_rready(rr), .o_high_out(ho), .o_low_out(lo), .o_irq(irq));
	// ============================================================
	// Verdict, comparisons and bus tasks
	task finish_test;
		begin
			if (n_errors == 0 && n_tests > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask
	task check(input [31:0] got, input [31:0] exp);
		begin
			n_tests = n_tests + 1;
			if (got !== exp) begin
				n_errors = n_errors + 1;
				$display("mismatch at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	// Count deltas carry a small bus-latency slack
	task check_rng(input [7:0] got, input [7:0] lo_v, input [7:0] hi_v);
		begin
			n_tests = n_tests + 1;
			if ((got >= lo_v && got <= hi_v) !== 1'b1) begin
				n_errors = n_errors + 1;
				$display("mismatch at %0t: count step %h out of range", $time, got);
			end
		end
	endtask
	// bready raised only after bvalid, so the hold of the answer is exercised
	task wr(input [31:0] a, input [7:0] d);
		begin
			awa <= a;
			wd <= {24'h0, d};
			ws <= 4'hF;
			awv <= 1'b1;
			wv <= 1'b1;
			@(posedge i_mclk);
			while (awv || wv) begin
				if (awr) awv <= 1'b0;
				if (wr_rdy) wv <= 1'b0;
				@(posedge i_mclk);
			end
			while (!bv) @(posedge i_mclk);
			br <= 1'b1;
			@(posedge i_mclk);
			rs = bresp;
			br <= 1'b0;
		end
	endtask
	task rd_reg(input [31:0] a);
		begin
			ara <= a;
			arv <= 1'b1;
			@(posedge i_mclk);
			while (!arr) @(posedge i_mclk);
			arv <= 1'b0;
			while (!rv) @(posedge i_mclk);
			rr <= 1'b1;
			@(posedge i_mclk);
			rd = rdata;
			rs = rresp;
			rr <= 1'b0;
		end
	endtask
	task pulse(input integer n);
		repeat (n) begin
			ev <= 1'b1;
			repeat (8) @(posedge i_mclk);
			ev <= 1'b0;
			repeat (8) @(posedge i_mclk);
		end
	endtask
	// ============================================================
	// Scenarios
	task t_reset;
		begin
			rd_reg(A_CTRL);
			check(rd, 32'h0);
			rd_reg(A_HCMP);
			check(rd, {24'h0, `DTP_RST_CMP});
			rd_reg(A_LCMP);
			check(rd, {24'h0, `DTP_RST_CMP});
			rd_reg(A_LCNT);
			check(rd, {24'h0, `DTP_RST_CNT});
			rd_reg(A_FLG);
			check(rd, 32'h0);
			rd_reg(32'h00000010);
			check(rs, `DTP_RESP_SLVERR);
			// Response taken at the handshake edge, while it stands
			wr(32'h00000012, 8'h01);
			check(rs, `DTP_RESP_SLVERR);
			wr(A_LCMP, 8'h3C);
			rd_reg(A_LCMP);
			check(rd, 32'h3C);
		end
	endtask
	task t_levels;
		for (k = 0; k < 4; k = k + 1) begin
			wr(A_CTRL, {k[1], 3'h0, k[0], 3'h0});
			repeat (3) @(posedge i_mclk);
			check(ho, k[1]);
			check(lo, k[0]);
			rd_reg(A_CTRL);
			check(rd, 32'h0);
		end
	endtask
	// Event source on rising, then falling edges; a match on 14 toggles the low output
	task t_event;
		begin
			wr(A_CTRL, 8'h00);
			wr(A_LCNT, 8'h10);
			pulse(3);
			rd_reg(A_LCNT);
			check(rd, 32'h13);
			wr(A_FLG, 8'h01);
			wr(A_LCMP, 8'h14);
			pulse(3);
			rd_reg(A_LCNT);
			check(rd, 32'h16);
			check(lo, 1'b1);
		end
	endtask
	// Status holds both overflows and the earlier low match
	task t_flag;
		begin
			wr(A_HCNT, 8'hFF);
			wr(A_LCNT, 8'hFF);
			pulse(1);
			rd_reg(A_LCNT);
			check(rd, 32'h0);
			rd_reg(A_HCNT);
			check(rd, 32'h0);
			rd_reg(A_STS);
			check(rd, 32'hB);
			rd_reg(A_FLG);
			check(rd[7], 1'b1);
			check(irq, 1'b0);
			wr(A_MASK, 8'h01);
			repeat (2) @(posedge i_mclk);
			check(irq, 1'b1);
			wr(A_FLG, 8'h80);
			wr(A_FLG, 8'h00);
			rd_reg(A_FLG);
			check(rd[7], 1'b1);
			wr(A_FLG, 8'h00);
			rd_reg(A_FLG);
			check(rd[7], 1'b0);
			wr(A_STS, 8'h01);
			repeat (2) @(posedge i_mclk);
			check(irq, 1'b0);
		end
	endtask
	// Internal divider rates on both halves
	task t_rate;
		reg [7:0] l0, h0;
		integer dv;
		for (k = 4; k < 8; k = k + 1) begin
			dv = (k == 4) ? 32 : (k == 5) ? 16 : (k == 6) ? 4 : 2;
			wr(A_CTRL, {1'b0, k[2:0], 1'b0, k[2:0]});
			rd_reg(A_LCNT);
			l0 = rd[7:0];
			rd_reg(A_HCNT);
			h0 = rd[7:0];
			repeat (320) @(posedge i_mclk);
			rd_reg(A_LCNT);
			check_rng(rd[7:0] - l0, 320 / dv, 340 / dv + 1);
			rd_reg(A_HCNT);
			check_rng(rd[7:0] - h0, 320 / dv, 340 / dv + 1);
		end
	endtask
	initial begin
		repeat (10) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		@(posedge i_mclk);
		t_reset;
		t_levels;
		t_event;
		t_flag;
		t_rate;
		finish_test;
	end
	// Watchdog well beyond the roughly 1700 cycles the scenarios need
	initial begin
		repeat (20000) @(posedge i_mclk);
		n_errors = n_errors + 1;
		finish_test;
	end
endmodule // dtp_timer_test
